// [asp_core.v]
// Purpose: register set and clock/mode/pdm logic of the audio serial block
// Assumes: single pclk domain, APB slave, pins synchronised here
// Notes:   one wait state on every APB access
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "asp_map.vh"

// Behaviour
// - camera internal validation bit makes the block validate camera data itself
// - external converter start bit enables start pulses to an external ADC
// - lcd mode enable bit puts the serial interface into LCD output mode
// - in LCD mode pair duplication sends each data pair twice
// - in LCD mode double write outputs every datum twice in a row
// - camera mode enable bit puts the interface into camera capture mode
// - master divider has integral bits 7..0, numerator and denominator fields
// - audio pll enable bit selects the pll clock as divider input
// - receive and transmit each own a sample bit length field
// - bit clock uses separate divider fields for receive and transmit
// - high-pass bypass bit skips the transmit pdm high-pass stage
// - receive filter group 1 decimates by 128 when set, 64 when clear
// - scale codes: 0 halves, 1 passes, 2 doubles, 3 quadruples
// - transmit pdm upsampling ratio is 64 times the oversample field
// - pdm to pcm conversion runs only while its enable bit is set
// - pcm to pdm conversion runs only while its enable bit is set
// - receive and transmit pdm modes have independent enable bits
// - pdm output and pcm input frequency params only go out on ports; the pcm to pdm converter does not use them
// - fifo reset status reads 1 while reset runs, 0 when done
// - transmitter status reads 1 when idle, 0 when busy
module asp_core (
  input wire pclk, // apb clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  input wire apll_clk_pin, // audio pll clock, sampled
  input wire pdm_rx_pin, // pdm microphone data
  input wire [7:0] cam_data_pin, // camera data bus
  input wire cam_valid_pin, // camera external data valid
  input wire [15:0] tx_sample, // pcm sample from data path
  input wire tx_sample_valid, // sample offered
  output wire tx_sample_ready, // sample taken
  output reg mclk_tick, // divided master clock pulse
  output reg rx_bck_tick, // receive bit clock pulse
  output reg tx_bck_tick, // transmit bit clock pulse
  output wire [5:0] rx_sample_bits, // receive sample length
  output wire [5:0] tx_sample_bits, // transmit sample length
  output wire [9:0] pdm_out_freq, // pdm output rate parameter
  output wire [9:0] pcm_in_freq, // pcm input rate parameter
  output reg [15:0] lcd_data, // lcd output word
  output reg lcd_strobe, // lcd word pulse
  output reg [7:0] cam_word, // captured camera byte
  output reg cam_strobe, // captured byte pulse
  output reg adc_start, // external converter start pulse
  output reg pdm_tx_bit, // pdm output stream
  output reg [15:0] rx_pcm, // decimated pcm sample
  output reg rx_pcm_valid, // pcm sample pulse
  output wire rx_fifo_rst, // rx fifo reset in progress
  output wire tx_fifo_rst // tx fifo reset in progress
);
  localparam LS_IDLE = 3'b001;
  localparam LS_PAIR = 3'b010;
  localparam LS_SEND = 3'b100;

  reg [31:0] mode_q, clkm_q, srate_q, pdm_q, pfreq_q;
  reg ack_q;
  reg [2:0] apll_s_q, pdm_s_q;
  reg [7:0] cam_d1_q, cam_d2_q;
  reg [1:0] camv_s_q;
  reg [3:0] rxr_cnt_q, txr_cnt_q;
  reg [8:0] mdiv_cnt_q;
  reg [5:0] frac_acc_q;
  reg mdiv_long_q;
  reg [5:0] rxb_cnt_q, txb_cnt_q;
  reg [2:0] ls_q;
  reg [15:0] w0_q, w1_q;
  reg [2:0] slot_q;
  reg [9:0] osr_cnt_q;
  reg signed [19:0] cur_q, hp_prev_q, lp_prev_q, sd_acc_q;
  reg [7:0] dsr_cnt_q, ones_q;
  reg [15:0] rd_d;
  reg map_hit;
  reg [31:0] prdata_mux;
  wire tx_idle;

  wire wr_en = psel & penable & pwrite & ack_q;
  wire lcd_en = mode_q[`ASP_MC_LCD];
  wire wrx2 = mode_q[`ASP_MC_WRX2];
  wire sdx2 = mode_q[`ASP_MC_SDX2];
  wire [7:0] div_int = clkm_q[`ASP_CK_INT_LSB +: 8];
  wire [5:0] div_num = clkm_q[`ASP_CK_NUMER_LSB +: 6];
  wire [5:0] div_den = clkm_q[`ASP_CK_DENOM_LSB +: 6];
  wire [5:0] tx_bck = srate_q[`ASP_SR_TX_BCK_LSB +: 6];
  wire [5:0] rx_bck = srate_q[`ASP_SR_RX_BCK_LSB +: 6];
  wire tx_pdm = pdm_q[`ASP_PD_TX_EN];
  wire rx_pdm = pdm_q[`ASP_PD_RX_EN];
  wire [3:0] osr = pdm_q[`ASP_PD_OSR_LSB +: 4];

  assign pready = ack_q;
  assign pslverr = ack_q & ~map_hit;
  assign tx_sample_bits = srate_q[`ASP_SR_TX_BITS_LSB +: 6];
  assign rx_sample_bits = srate_q[`ASP_SR_RX_BITS_LSB +: 6];
  assign pdm_out_freq = pfreq_q[`ASP_PF_FP_LSB +: 10];
  assign pcm_in_freq = pfreq_q[`ASP_PF_FS_LSB +: 10];
  assign rx_fifo_rst = (rxr_cnt_q != 4'h0);
  assign tx_fifo_rst = (txr_cnt_q != 4'h0);

  // scale a filter input by a 2-bit code
  function signed [19:0] scl;
    input signed [19:0] x;
    input [1:0] code;
    begin
      case (code)
        2'd0: scl = x >>> 1;
        2'd1: scl = x;
        2'd2: scl = x <<< 1;
        default: scl = x <<< 2;
      endcase
    end
  endfunction

  // apb decode and read mux
  always @* begin
    map_hit = 1'b1;
    rd_d = 16'h0000;
    prdata_mux = 32'h0000_0000;
    case (paddr)
      `ASP_OFF_MODE_CTRL: prdata_mux = mode_q;
      `ASP_OFF_CLKM: prdata_mux = clkm_q;
      `ASP_OFF_SRATE: prdata_mux = srate_q;
      `ASP_OFF_PDM: prdata_mux = pdm_q;
      `ASP_OFF_PDM_FREQ: prdata_mux = pfreq_q;
      `ASP_OFF_STATE: begin
        rd_d[`ASP_ST_RX_RST] = rx_fifo_rst;
        rd_d[`ASP_ST_TX_RST] = tx_fifo_rst;
        rd_d[`ASP_ST_TX_IDLE] = tx_idle;
        prdata_mux = {16'h0000, rd_d};
      end
      `ASP_OFF_FIFO_RST: prdata_mux = 32'h0000_0000;
      default: map_hit = 1'b0;
    endcase
  end

  // apb handshake, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ack_q <= psel & penable & ~ack_q;
      if (psel & penable & ~ack_q & ~pwrite)
        prdata <= prdata_mux;
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `ASP_MC_RESET;
      clkm_q <= `ASP_CK_RESET;
      srate_q <= `ASP_SR_RESET;
      pdm_q <= `ASP_PD_RESET;
      pfreq_q <= `ASP_PF_RESET;
    end else if (wr_en) begin
      case (paddr)
        `ASP_OFF_MODE_CTRL: mode_q <= {24'h00_0000, pwdata[7:5], 2'b00,
          pwdata[2:0]};
        `ASP_OFF_CLKM: clkm_q <= {10'h000, pwdata[21:0]};
        `ASP_OFF_SRATE: srate_q <= {8'h00, pwdata[23:0]};
        `ASP_OFF_PDM: pdm_q <= {6'h00, pwdata[25], 8'h00, pwdata[16:0]};
        `ASP_OFF_PDM_FREQ: pfreq_q <= {12'h000, pwdata[19:0]};
        default: ;
      endcase
    end
  end

  // fifo reset runs a fixed count, status reads busy meanwhile
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxr_cnt_q <= 4'h0;
      txr_cnt_q <= 4'h0;
    end else begin
      if (wr_en && paddr == `ASP_OFF_FIFO_RST && pwdata[`ASP_FR_RX])
        rxr_cnt_q <= `ASP_FIFO_RST_CYCLES;
      else if (rx_fifo_rst)
        rxr_cnt_q <= rxr_cnt_q - 4'h1;
      if (wr_en && paddr == `ASP_OFF_FIFO_RST && pwdata[`ASP_FR_TX])
        txr_cnt_q <= `ASP_FIFO_RST_CYCLES;
      else if (tx_fifo_rst)
        txr_cnt_q <= txr_cnt_q - 4'h1;
    end
  end

  // pin synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apll_s_q <= 3'b000;
      pdm_s_q <= 3'b000;
      cam_d1_q <= 8'h00;
      cam_d2_q <= 8'h00;
      camv_s_q <= 2'b00;
    end else begin
      apll_s_q <= {apll_s_q[1:0], apll_clk_pin};
      pdm_s_q <= {pdm_s_q[1:0], pdm_rx_pin};
      cam_d1_q <= cam_data_pin;
      cam_d2_q <= cam_d1_q;
      camv_s_q <= {camv_s_q[0], cam_valid_pin};
    end
  end

  // fractional master divider; long periods spread the fraction
  wire src_tick = clkm_q[`ASP_CK_APLL] ?
    (apll_s_q[1] & ~apll_s_q[2]) : 1'b1;
  wire [8:0] period = {1'b0, (div_int == 8'h00) ? 8'h01 : div_int} +
    {8'h00, mdiv_long_q};
  wire [6:0] acc_sum = {1'b0, frac_acc_q} + {1'b0, div_num};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdiv_cnt_q <= 9'h000;
      frac_acc_q <= 6'h00;
      mdiv_long_q <= 1'b0;
      mclk_tick <= 1'b0;
    end else begin
      mclk_tick <= 1'b0;
      if (src_tick) begin
        if (mdiv_cnt_q + 9'h001 >= period) begin
          mdiv_cnt_q <= 9'h000;
          mclk_tick <= 1'b1;
          if (div_den != 6'h00 && acc_sum >= {1'b0, div_den}) begin
            frac_acc_q <= acc_sum[5:0] - div_den;
            mdiv_long_q <= 1'b1;
          end else begin
            frac_acc_q <= (div_den == 6'h00) ? 6'h00 : acc_sum[5:0];
            mdiv_long_q <= 1'b0;
          end
        end else begin
          mdiv_cnt_q <= mdiv_cnt_q + 9'h001;
        end
      end
    end
  end

  // separate bit clock dividers per direction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxb_cnt_q <= 6'h00;
      txb_cnt_q <= 6'h00;
      rx_bck_tick <= 1'b0;
      tx_bck_tick <= 1'b0;
    end else begin
      rx_bck_tick <= 1'b0;
      tx_bck_tick <= 1'b0;
      if (mclk_tick) begin
        if (rxb_cnt_q + 6'h01 >= rx_bck) begin
          rxb_cnt_q <= 6'h00;
          rx_bck_tick <= 1'b1;
        end else
          rxb_cnt_q <= rxb_cnt_q + 6'h01;
        if (txb_cnt_q + 6'h01 >= tx_bck) begin
          txb_cnt_q <= 6'h00;
          tx_bck_tick <= 1'b1;
        end else
          txb_cnt_q <= txb_cnt_q + 6'h01;
      end
    end
  end

  // camera capture and external converter start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_word <= 8'h00;
      cam_strobe <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      cam_strobe <= 1'b0;
      adc_start <= mode_q[`ASP_MC_EXT_ADC] & rx_bck_tick;
      if (mode_q[`ASP_MC_CAMERA] && (mode_q[`ASP_MC_INTER_VALID] ?
          rx_bck_tick : camv_s_q[1])) begin
        cam_word <= cam_d2_q;
        cam_strobe <= 1'b1;
      end
    end
  end

  // lcd output: slot index picks pair member and repeat
  wire [2:0] last_slot = sdx2 ? (wrx2 ? 3'd7 : 3'd3) :
    (wrx2 ? 3'd1 : 3'd0);
  wire pick_w1 = sdx2 & (wrx2 ? slot_q[1] : slot_q[0]);
  wire lcd_take = lcd_en & tx_sample_valid & (ls_q != LS_SEND);
  wire pdm_take = ~lcd_en & tx_pdm & pdm_q[`ASP_PD_PCM2PDM] &
    tx_bck_tick & (osr_cnt_q == 10'h000) & tx_sample_valid;
  assign tx_sample_ready = lcd_take | pdm_take;
  assign tx_idle = (ls_q == LS_IDLE) & ~(tx_pdm & tx_sample_valid);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_q <= LS_IDLE;
      w0_q <= 16'h0000;
      w1_q <= 16'h0000;
      slot_q <= 3'd0;
      lcd_data <= 16'h0000;
      lcd_strobe <= 1'b0;
    end else begin
      lcd_strobe <= 1'b0;
      case (ls_q)
        LS_IDLE: if (lcd_take) begin
          w0_q <= tx_sample;
          slot_q <= 3'd0;
          ls_q <= sdx2 ? LS_PAIR : LS_SEND;
        end
        LS_PAIR: if (lcd_take) begin
          w1_q <= tx_sample;
          ls_q <= LS_SEND;
        end
        LS_SEND: if (tx_bck_tick) begin
          lcd_data <= pick_w1 ? w1_q : w0_q;
          lcd_strobe <= 1'b1;
          if (slot_q >= last_slot)
            ls_q <= LS_IDLE;
          else
            slot_q <= slot_q + 3'd1;
        end
        default: ls_q <= LS_IDLE;
      endcase
      if (!lcd_en)
        ls_q <= LS_IDLE;
    end
  end

  // pcm to pdm: scaled filter chain into first order modulator
  wire [1:0] hp_sh = pdm_q[`ASP_PD_HP_SH_LSB +: 2];
  wire [1:0] lp_sh = pdm_q[`ASP_PD_LP_SH_LSB +: 2];
  wire [1:0] sinc_sh = pdm_q[`ASP_PD_SINC_SH_LSB +: 2];
  wire [1:0] sd_sh = pdm_q[`ASP_PD_SD_SH_LSB +: 2];
  wire signed [19:0] hp_in = scl(cur_q, hp_sh);
  wire signed [19:0] hp_out = pdm_q[`ASP_PD_HP_BYPASS] ? hp_in :
    hp_in - (hp_prev_q >>> 1);
  wire signed [19:0] lp_in = scl(hp_out, lp_sh);
  wire signed [19:0] lp_out = (lp_in >>> 1) + (lp_prev_q >>> 1);
  wire signed [19:0] sinc_out = scl(lp_out, sinc_sh);
  wire signed [19:0] sd_in = scl(sinc_out, sd_sh);
  wire signed [19:0] fb = pdm_tx_bit ? 20'sh08000 : -20'sh08000;
  // osr times 64, less one, as the window's last count
  wire [9:0] osr_top = {osr, 6'h00} - 10'h001;
  wire pdm_tx_run = ~lcd_en & tx_pdm & pdm_q[`ASP_PD_PCM2PDM];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osr_cnt_q <= 10'h000;
      cur_q <= 20'sh00000;
      hp_prev_q <= 20'sh00000;
      lp_prev_q <= 20'sh00000;
      sd_acc_q <= 20'sh00000;
      pdm_tx_bit <= 1'b0;
    end else if (!pdm_tx_run) begin
      osr_cnt_q <= 10'h000;
      pdm_tx_bit <= 1'b0;
    end else if (tx_bck_tick) begin
      osr_cnt_q <= (osr_cnt_q >= osr_top) ? 10'h000 :
        osr_cnt_q + 10'h001;
      if (pdm_take) begin
        cur_q <= {{4{tx_sample[15]}}, tx_sample};
        hp_prev_q <= hp_in;
        lp_prev_q <= lp_in;
      end
      sd_acc_q <= sd_acc_q + sd_in - fb;
      pdm_tx_bit <= ~sd_acc_q[19];
    end
  end

  // pdm to pcm: count ones over the decimation window
  wire [7:0] dsr_top = pdm_q[`ASP_PD_RX_DSR] ? `ASP_DSR_HI :
    `ASP_DSR_LO;
  wire pdm_rx_run = rx_pdm & pdm_q[`ASP_PD_PDM2PCM];
  wire [7:0] ones_nx = ones_q + {7'h00, pdm_s_q[1]};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_cnt_q <= 8'h00;
      ones_q <= 8'h00;
      rx_pcm <= 16'h0000;
      rx_pcm_valid <= 1'b0;
    end else begin
      rx_pcm_valid <= 1'b0;
      if (!pdm_rx_run) begin
        dsr_cnt_q <= 8'h00;
        ones_q <= 8'h00;
      end else if (rx_bck_tick) begin
        if (dsr_cnt_q + 8'h01 >= dsr_top) begin
          dsr_cnt_q <= 8'h00;
          ones_q <= 8'h00;
          rx_pcm_valid <= 1'b1;
          rx_pcm <= pdm_q[`ASP_PD_RX_DSR] ?
            {ones_nx[7:0], 8'h00} - 16'h8000 :
            {ones_nx[6:0], 9'h000} - 16'h8000;
        end else begin
          dsr_cnt_q <= dsr_cnt_q + 8'h01;
          ones_q <= ones_nx;
        end
      end
    end
  end

endmodule // asp_core

// [asp_map.vh]
// Purpose: register offsets, field positions and reset values of the
//          audio serial configuration block
// Assumes: 32-bit APB data, byte addresses
// Notes:   definitions only
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// register byte offsets
`define ASP_OFF_MODE_CTRL 12'h00a8
`define ASP_OFF_CLKM 12'h00ac
`define ASP_OFF_SRATE 12'h00b0
`define ASP_OFF_PDM 12'h00b4
`define ASP_OFF_PDM_FREQ 12'h00b8
`define ASP_OFF_STATE 12'h00bc
`define ASP_OFF_FIFO_RST 12'h00c0

// mode control fields
`define ASP_MC_CAMERA 0
`define ASP_MC_WRX2 1
`define ASP_MC_SDX2 2
`define ASP_MC_LCD 5
`define ASP_MC_EXT_ADC 6
`define ASP_MC_INTER_VALID 7
`define ASP_MC_RESET 32'h0000_0000

// master clock divider fields
`define ASP_CK_INT_LSB 0
`define ASP_CK_NUMER_LSB 8
`define ASP_CK_DENOM_LSB 14
`define ASP_CK_APLL 21
`define ASP_CK_RESET 32'h0000_0004

// sample rate fields, 6 bits each
`define ASP_SR_TX_BCK_LSB 0
`define ASP_SR_RX_BCK_LSB 6
`define ASP_SR_TX_BITS_LSB 12
`define ASP_SR_RX_BITS_LSB 18
`define ASP_SR_RESET 32'h0041_0186

// pdm control fields
`define ASP_PD_TX_EN 0
`define ASP_PD_RX_EN 1
`define ASP_PD_PCM2PDM 2
`define ASP_PD_PDM2PCM 3
`define ASP_PD_OSR_LSB 4
`define ASP_PD_HP_SH_LSB 8
`define ASP_PD_LP_SH_LSB 10
`define ASP_PD_SINC_SH_LSB 12
`define ASP_PD_SD_SH_LSB 14
`define ASP_PD_RX_DSR 16
`define ASP_PD_HP_BYPASS 25
`define ASP_PD_RESET 32'h0000_5510

// pdm frequency fields, 10 bits each
`define ASP_PF_FS_LSB 0
`define ASP_PF_FP_LSB 10
`define ASP_PF_RESET 32'h0000_0000

// state and fifo reset fields
`define ASP_ST_RX_RST 0
`define ASP_ST_TX_RST 1
`define ASP_ST_TX_IDLE 2
`define ASP_FR_RX 0
`define ASP_FR_TX 1

// timing and ratios
`define ASP_FIFO_RST_CYCLES 4'h8
`define ASP_DSR_HI 8'h80
`define ASP_DSR_LO 8'h40
`define ASP_OSR_UNIT 4'h6

`endif

// [asp_far_side.sv]
// Purpose: far side model: audio pll source, pdm microphone, camera
// Assumes: mic shifts one bit per receive bit clock pulse
// Notes: camera valid held low, bench uses internal validation
`timescale 1ns/10ps
module asp_far_side (
  input wire logic pclk, // bench clock
  input wire logic rx_bck_tick, // mic shift pulse
  output logic apll_clk_pin, // audio pll clock, 120 ns
  output logic pdm_rx_pin, // mic bit stream
  output logic [7:0] cam_data_pin, // camera bus
  output logic cam_valid_pin // camera valid
);
  logic [7:0] cnt_q = 8'h00;
  initial begin
    apll_clk_pin = 1'b0;
    #7;
    forever #60 apll_clk_pin = ~apll_clk_pin;
  end
  always @(posedge pclk) begin
    if (rx_bck_tick) cnt_q <= cnt_q + 8'h01;
  end
  assign pdm_rx_pin = cnt_q[0] ^ cnt_q[3];
  assign cam_data_pin = cnt_q;
  assign cam_valid_pin = 1'b0;
endmodule // asp_far_side

// [asp_core_properties.sv]
// Purpose: port-level checks of the audio serial config block
// Assumes: register shadow follows completed APB writes
// Notes: bound to asp_core below
`timescale 1ns/10ps
`include "asp_map.vh"
module asp_core_properties (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [5:0] rx_sample_bits, // rx length
  input wire logic [5:0] tx_sample_bits, // tx length
  input wire logic [9:0] pdm_out_freq, // pdm rate
  input wire logic [9:0] pcm_in_freq, // pcm rate
  input wire logic cam_strobe, // camera pulse
  input wire logic adc_start, // adc start pulse
  input wire logic rx_bck_tick, // rx bit clock
  input wire logic lcd_strobe, // lcd pulse
  input wire logic rx_pcm_valid, // pcm pulse
  input wire logic tx_sample_ready, // sample taken
  input wire logic rx_fifo_rst // rx fifo reset busy
);
  logic [31:0] mode_q, srate_q, pdm_q, freq_q;
  wire wr = psel & penable & pready & pwrite;
  wire mapped = paddr >= `ASP_OFF_MODE_CTRL && paddr <= `ASP_OFF_FIFO_RST
    && paddr[1:0] == 2'b00;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 32'h0000_0000;
      srate_q <= `ASP_SR_RESET;
      pdm_q <= `ASP_PD_RESET;
      freq_q <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == `ASP_OFF_MODE_CTRL) mode_q <= pwdata;
      if (paddr == `ASP_OFF_SRATE) srate_q <= pwdata;
      if (paddr == `ASP_OFF_PDM) pdm_q <= pwdata;
      if (paddr == `ASP_OFF_PDM_FREQ) freq_q <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_rx_rst;
    wr && paddr == `ASP_OFF_FIFO_RST && pwdata[0];
  endsequence
  a_apb_one_wait: assert property (s_setup |-> !pready ##1 pready)
    else $error("apb wait state count wrong");
  a_unmapped_err: assert property (psel && penable && pready |->
    pslverr == !mapped) else $error("slave error flag wrong");
  a_fifo_rst_len: assert property (s_rx_rst |=> rx_fifo_rst [*8] ##1
    !rx_fifo_rst) else $error("fifo reset length wrong");
  a_bits_fields: assert property (rx_sample_bits == srate_q[23:18] &&
    tx_sample_bits == srate_q[17:12]) else $error("sample bits wrong");
  a_freq_fields: assert property (pdm_out_freq == freq_q[19:10] &&
    pcm_in_freq == freq_q[9:0]) else $error("frequency params wrong");
  a_adc_cause: assert property (adc_start |-> $past(rx_bck_tick) &&
    $past(mode_q[6])) else $error("adc start without cause");
  a_cam_gate: assert property (cam_strobe |-> mode_q[0] ||
    $past(mode_q[0]) || $past(mode_q[0], 2)) else $error("camera off");
  a_pcm_gate: assert property (rx_pcm_valid |-> pdm_q[1] && pdm_q[3] ||
    $past(pdm_q[1] && pdm_q[3])) else $error("pcm while off");
  a_ready_gate: assert property (tx_sample_ready |-> mode_q[5] ||
    pdm_q[0] && pdm_q[2]) else $error("sample taken while no mode");
  a_lcd_gate: assert property (lcd_strobe |-> mode_q[5] ||
    $past(mode_q[5])) else $error("lcd strobe outside lcd mode");
endmodule // asp_core_properties
bind asp_core asp_core_properties i_chk (.*);

// [audio_serial_pdm_clock_config_tb.sv]
// Purpose: self-checking bench of the audio serial config block
// Assumes: one-wait apb slave, far side model drives the pins
// Notes: clock tests use a warm-up pulse before measuring
`timescale 1ns/10ps
`include "asp_map.vh"
`define CHK(nm, ex, g) begin n_compared++; if ((g) !== (ex)) begin \
  miscompares++; $display("MISMATCH %s exp %0h got %0h", nm, ex, g); end end
module audio_serial_pdm_clock_config_tb;
  logic pclk, presetn, psel, penable, pwrite, tx_sample_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  logic [15:0] tx_sample;
  logic [15:0] q[$], x[$];
  wire [31:0] prdata;
  wire pready, pslverr, apll, pdm_bit, cam_v, tx_sample_ready, mclk_tick;
  wire rx_bck_tick, tx_bck_tick, lcd_strobe, cam_strobe, adc_start, rx_pcm_valid;
  wire [5:0] rx_sample_bits, tx_sample_bits;
  wire [9:0] pdm_out_freq, pcm_in_freq;
  wire [15:0] lcd_data;
  wire [7:0] cam_d;
  int miscompares, n_compared, cyc, n, k;
  wire [6:0] ev = {adc_start, cam_strobe, rx_pcm_valid,
    tx_sample_ready & tx_sample_valid, tx_bck_tick, rx_bck_tick, mclk_tick};
  // write flag, address, write data, expected read, expected error
  logic [77:0] rows [0:12] = '{
    {1'b0, 12'h0a8, 32'h0, 32'h0000_0000, 1'b0},
    {1'b0, 12'h0ac, 32'h0, 32'h0000_0004, 1'b0},
    {1'b0, 12'h0b0, 32'h0, 32'h0041_0186, 1'b0},
    {1'b0, 12'h0b4, 32'h0, 32'h0000_5510, 1'b0},
    {1'b0, 12'h0b8, 32'h0, 32'h0000_0000, 1'b0},
    {1'b0, 12'h0bc, 32'h0, 32'h0000_0004, 1'b0},
    {1'b0, 12'h0c0, 32'h0, 32'h0000_0000, 1'b0},
    {1'b1, 12'h0a8, 32'hffff_ffff, 32'h0000_00e7, 1'b0},
    {1'b1, 12'h0ac, 32'hffff_ffff, 32'h003f_ffff, 1'b0},
    {1'b1, 12'h0b0, 32'hffff_ffff, 32'h00ff_ffff, 1'b0},
    {1'b1, 12'h0b4, 32'hffff_ffff, 32'h0201_ffff, 1'b0},
    {1'b1, 12'h0b8, 32'hffff_ffff, 32'h000f_ffff, 1'b0},
    {1'b1, 12'h000, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  // camera/adc mode, camera pulses expected, adc pulses expected
  logic [9:0] ctab [0:3] = '{{8'h81, 2'b10}, {8'h01, 2'b00},
    {8'h40, 2'b01}, {8'h00, 2'b00}};
  asp_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .apll_clk_pin(apll), .pdm_rx_pin(pdm_bit), .cam_data_pin(cam_d),
    .cam_valid_pin(cam_v), .tx_sample(tx_sample),
    .tx_sample_valid(tx_sample_valid), .tx_sample_ready(tx_sample_ready),
    .mclk_tick(mclk_tick), .rx_bck_tick(rx_bck_tick),
    .tx_bck_tick(tx_bck_tick), .rx_sample_bits(rx_sample_bits),
    .tx_sample_bits(tx_sample_bits), .pdm_out_freq(pdm_out_freq),
    .pcm_in_freq(pcm_in_freq), .lcd_data(lcd_data), .lcd_strobe(lcd_strobe),
    .cam_word(), .cam_strobe(cam_strobe), .adc_start(adc_start),
    .pdm_tx_bit(), .rx_pcm(), .rx_pcm_valid(rx_pcm_valid),
    .rx_fifo_rst(), .tx_fifo_rst());
  asp_far_side i_far (.pclk(pclk), .rx_bck_tick(rx_bck_tick),
    .apll_clk_pin(apll), .pdm_rx_pin(pdm_bit), .cam_data_pin(cam_d),
    .cam_valid_pin(cam_v));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (lcd_strobe === 1'b1) q.push_back(lcd_data);
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits two pulses of event i, then counts cycles over np periods
  task gap(input int i, input int np);
    k = 0;
    n = 0;
    repeat (2) do @(posedge pclk); while (ev[i] !== 1'b1 && ++k < 900);
    repeat (np) do begin @(posedge pclk); n++; end
      while (ev[i] !== 1'b1 && n < 500);
  endtask
  task cnt(input int i, input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (ev[i] === 1'b1) n++;
    end
  endtask
  task send(input logic [15:0] v);
    @(posedge pclk);
    tx_sample <= v;
    tx_sample_valid <= 1'b1;
    k = 0;
    do @(posedge pclk); while (tx_sample_ready !== 1'b1 && ++k < 200);
    tx_sample_valid <= 1'b0;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, tx_sample_valid} = 5'b00000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tx_sample = 16'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][77]) apb(1'b1, rows[i][76:65], rows[i][64:33]);
      apb(1'b0, rows[i][76:65], 32'h0000_0000);
      `CHK("reg", rows[i][32:1], r)
      `CHK("err", rows[i][0], e)
    end
    apb(1'b1, `ASP_OFF_MODE_CTRL, 32'h0000_0000);
    apb(1'b1, `ASP_OFF_PDM, 32'h0000_0000);
    apb(1'b1, `ASP_OFF_CLKM, 32'h0000_0005);
    gap(0, 1);
    `CHK("mclk", 5, n)
    apb(1'b1, `ASP_OFF_CLKM, 32'h0000_8104);
    gap(0, 2);
    `CHK("mclk_frac", 9, n)
    apb(1'b1, `ASP_OFF_CLKM, 32'h0020_0001);
    gap(0, 2);
    `CHK("mclk_pll", 12, n)
    apb(1'b1, `ASP_OFF_CLKM, 32'h0000_0002);
    apb(1'b1, `ASP_OFF_SRATE, 32'h0061_0083);
    gap(1, 1);
    `CHK("rx_bck", 4, n)
    gap(2, 1);
    `CHK("tx_bck", 6, n)
    `CHK("rx_bits", 6'd24, rx_sample_bits)
    `CHK("tx_bits", 6'd16, tx_sample_bits)
    apb(1'b1, `ASP_OFF_PDM_FREQ, 32'h0000_2805);
    @(posedge pclk);
    `CHK("pdm_freq", 10'd10, pdm_out_freq)
    `CHK("pcm_freq", 10'd5, pcm_in_freq)
    apb(1'b1, `ASP_OFF_FIFO_RST, 32'h0000_0003);
    apb(1'b0, `ASP_OFF_STATE, 32'h0000_0000);
    `CHK("fifo_busy", 2'b11, r[1:0])
    while (r[1:0] !== 2'b00 && ++k < 10) apb(1'b0, `ASP_OFF_STATE, 32'h0);
    `CHK("fifo_done", 2'b00, r[1:0])
    apb(1'b1, `ASP_OFF_CLKM, 32'h0000_0001);
    apb(1'b1, `ASP_OFF_SRATE, 32'h0000_0041);
    for (int m = 0; m < 4; m++) begin
      q.delete();
      x.delete();
      for (int p = 0; p <= m[1]; p++)
        for (int w = 0; w < 2; w++)
          repeat (m[0] + 1) x.push_back(w ? 16'h5678 : 16'h1234);
      apb(1'b1, `ASP_OFF_MODE_CTRL, 32'h0000_0020 | (m << 1));
      send(16'h1234);
      send(16'h5678);
      k = 0;
      while (q.size() < x.size() && ++k < 200) @(posedge pclk);
      repeat (4) @(posedge pclk);
      `CHK("lcd_len", x.size(), q.size())
      foreach (x[j]) `CHK("lcd_word", x[j], q[j])
    end
    foreach (ctab[i]) begin
      apb(1'b1, `ASP_OFF_MODE_CTRL, {24'h00_0000, ctab[i][9:2]});
      // let a strobe launched under the previous mode drain
      repeat (2) @(posedge pclk);
      cnt(5, 40);
      `CHK("cam", ctab[i][1], n != 0)
      cnt(6, 40);
      `CHK("adc", ctab[i][0], n != 0)
    end
    apb(1'b1, `ASP_OFF_PDM, 32'h0000_000a);
    gap(4, 1);
    `CHK("dsr64", 64, n)
    apb(1'b1, `ASP_OFF_PDM, 32'h0001_000a);
    gap(4, 1);
    `CHK("dsr128", 128, n)
    apb(1'b1, `ASP_OFF_PDM, 32'h0000_0002);
    tx_sample_valid <= 1'b1;
    cnt(4, 150);
    `CHK("no_pcm", 0, n)
    cnt(3, 150);
    `CHK("no_take", 0, n)
    for (int o = 1; o < 3; o++) begin
      apb(1'b1, `ASP_OFF_PDM, 32'h0000_0005 | (o << 4));
      gap(3, 1);
      `CHK("osr", 64 * o, n)
      apb(1'b0, `ASP_OFF_STATE, 32'h0000_0000);
      `CHK("tx_busy", 1'b0, r[2])
    end
    tx_sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, `ASP_OFF_STATE, 32'h0000_0000);
    `CHK("tx_idle", 1'b1, r[2])
    end_of_test();
  end
endmodule // audio_serial_pdm_clock_config_tb
